// [shared/tail_exec_defs.svh]
`ifndef TAIL_EXEC_DEFS_SVH
`define TAIL_EXEC_DEFS_SVH
// Operation select codes on the op port.
`define OP_NONE 3'h0
`define OP_RETURN 3'h1
`define OP_SLEEP 3'h2
`define OP_LIT_SUB 3'h3
`define OP_LIT_XOR 3'h4
`define OP_FILE_SUB 3'h5
`define OP_FILE_XOR 3'h6
`define OP_NIBBLE 3'h7
`define WDT_CLEAR_VAL 8'h00
`define WDT_PRESCALE_CLEAR 8'h00
`define STATUS_C_BIT 0
`define STATUS_DC_BIT 1
`define STATUS_Z_BIT 2
`define STATUS_PD_BIT 3
`define STATUS_TO_BIT 4
`define STATUS_RESET 8'h18
`define ACC_RESET 8'h00
`define PC_RESET 13'h0000
`endif

// [shared/tail_exec_pkg.sv]
`default_nettype none
`include "tail_exec_defs.svh"
package tail_exec_pkg;
  typedef struct packed {
    logic [2:0] op;
    logic [7:0] literal;
    logic [6:0] file_addr;
    logic dest_file;
  } instr_t;
  typedef struct packed {
    logic [7:0] value;
    logic carry;
    logic half_carry;
    logic zero;
  } alu_out_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_RET_WAIT = 2'b01,
    ST_SLEEP = 2'b10
  } exec_state_t;
endpackage : tail_exec_pkg
`default_nettype wire

// [src/tail_alu.sv]
`timescale 1ns/100ps
`default_nettype none
`include "tail_exec_defs.svh"
module tail_alu
  import tail_exec_pkg::*;
(
  input wire logic [2:0] op, // Operation select
  input wire logic [7:0] acc, // Accumulator value
  input wire logic [7:0] operand, // Literal or file register value
  output alu_out_t res // Result and flags
);
  function automatic alu_out_t subtract(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    alu_out_t r;
    full = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    r.value = full[7:0];
    r.carry = full[8];
    r.half_carry = low[4];
    r.zero = (full[7:0] == 8'h00);
    return r;
  endfunction : subtract
  always_comb
  begin
    res = '0;
    case (op)
      `OP_LIT_SUB, `OP_FILE_SUB: res = subtract(operand, acc);
      `OP_LIT_XOR, `OP_FILE_XOR:
      begin
        res.value = acc ^ operand;
        res.zero = (res.value == 8'h00);
      end
      `OP_NIBBLE: res.value = {operand[3:0], operand[7:4]};
      default: res = '0;
    endcase
  end
endmodule : tail_alu
`default_nettype wire

// [src/tail_exec.sv]
// Contract
// - Return pops the stack and loads its former head into PC; flags untouched.
// - Return takes two cycles; the prefetched instruction is discarded.
// - Sleep clears watchdog and prescaler, sets expiry flag, clears powerdown flag.
// - After sleep the core halts the oscillator and stops executing.
// - Literal minus accumulator into accumulator, updating carry, half carry, zero.
// - Accumulator xor literal into accumulator, only zero flag changes.
// - File minus accumulator to chosen destination, updating carry, half carry, zero.
// - Accumulator xor file to chosen destination, only zero flag changes.
// - Nibble exchange of file register to destination, flags unchanged.
// - Destination bit zero selects accumulator, one selects file register.
`timescale 1ns/100ps
`default_nettype none
`include "tail_exec_defs.svh"
module tail_exec
  import tail_exec_pkg::*;
(
  input wire logic sys_clk, // Core instruction clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic instr_valid, // Instruction presented this cycle
  input wire instr_t instr, // Decoded instruction fields
  input wire logic [7:0] file_rdata, // Value of file register at instr.file_addr
  input wire logic [12:0] stack_head, // Current top of hardware stack
  input wire logic wake, // Wake request, leaves sleep
  output logic [7:0] acc_reg, // Accumulator
  output logic [7:0] status_reg, // Status flags
  output logic [12:0] pc_reg, // Program counter load value
  output logic pc_load_reg, // Pulse: load PC from pc_reg
  output logic stack_pop_reg, // Pulse: pop the hardware stack
  output logic flush_reg, // High while the prefetched word is discarded
  output logic file_we_reg, // Pulse: write file register
  output logic [6:0] file_waddr_reg, // File register write address
  output logic [7:0] file_wdata_reg, // File register write data
  output logic wdt_clear_reg, // Pulse: load watchdog and prescaler with clear values
  output logic [7:0] wdt_value_reg, // Value to load into watchdog counter
  output logic [7:0] wdt_prescale_reg, // Value to load into watchdog prescaler
  output logic osc_halt_reg, // High while the main oscillator is stopped
  output logic busy_reg // High while instructions are not accepted
);
  exec_state_t state_reg, state_next;
  logic [7:0] acc_next, status_next, file_wdata_next, wdt_value_next, wdt_prescale_next;
  logic [12:0] pc_next;
  logic [6:0] file_waddr_next;
  logic pc_load_next, stack_pop_next, flush_next, file_we_next, wdt_clear_next;
  logic osc_halt_next, busy_next;
  logic [7:0] operand;
  alu_out_t alu_res;
  logic is_lit;

  assign is_lit = (instr.op == `OP_LIT_SUB) || (instr.op == `OP_LIT_XOR);
  assign operand = is_lit ? instr.literal : file_rdata;

  tail_alu u_alu (
    .op(instr.op),
    .acc(acc_reg),
    .operand(operand),
    .res(alu_res)
  );

  always_comb
  begin
    state_next = state_reg;
    acc_next = acc_reg;
    status_next = status_reg;
    pc_next = pc_reg;
    pc_load_next = 1'b0;
    stack_pop_next = 1'b0;
    flush_next = 1'b0;
    file_we_next = 1'b0;
    file_waddr_next = file_waddr_reg;
    file_wdata_next = file_wdata_reg;
    wdt_clear_next = 1'b0;
    wdt_value_next = wdt_value_reg;
    wdt_prescale_next = wdt_prescale_reg;
    osc_halt_next = osc_halt_reg;
    busy_next = busy_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (instr_valid)
        begin
          case (instr.op)
            `OP_RETURN:
            begin
              pc_next = stack_head;
              pc_load_next = 1'b1;
              stack_pop_next = 1'b1;
              flush_next = 1'b1;
              busy_next = 1'b1;
              state_next = ST_RET_WAIT;
            end
            `OP_SLEEP:
            begin
              wdt_clear_next = 1'b1;
              wdt_value_next = `WDT_CLEAR_VAL;
              wdt_prescale_next = `WDT_PRESCALE_CLEAR;
              status_next[`STATUS_TO_BIT] = 1'b1;
              status_next[`STATUS_PD_BIT] = 1'b0;
              osc_halt_next = 1'b1;
              busy_next = 1'b1;
              state_next = ST_SLEEP;
            end
            `OP_LIT_SUB, `OP_LIT_XOR:
            begin
              acc_next = alu_res.value;
              status_next[`STATUS_Z_BIT] = alu_res.zero;
              if (instr.op == `OP_LIT_SUB)
              begin
                status_next[`STATUS_C_BIT] = alu_res.carry;
                status_next[`STATUS_DC_BIT] = alu_res.half_carry;
              end
            end
            `OP_FILE_SUB, `OP_FILE_XOR, `OP_NIBBLE:
            begin
              if (instr.dest_file)
              begin
                file_we_next = 1'b1;
                file_waddr_next = instr.file_addr;
                file_wdata_next = alu_res.value;
              end
              else
              begin
                acc_next = alu_res.value;
              end
              // The nibble exchange leaves every flag alone.
              if (instr.op != `OP_NIBBLE)
              begin
                status_next[`STATUS_Z_BIT] = alu_res.zero;
              end
              if (instr.op == `OP_FILE_SUB)
              begin
                status_next[`STATUS_C_BIT] = alu_res.carry;
                status_next[`STATUS_DC_BIT] = alu_res.half_carry;
              end
            end
            default: ;
          endcase
        end
      end
      ST_RET_WAIT:
      begin
        // Second cycle of the return: the discarded prefetch is swallowed here.
        busy_next = 1'b0;
        state_next = ST_RUN;
      end
      ST_SLEEP:
      begin
        // Wake-up handling proper lives elsewhere; this only releases the halt.
        if (wake)
        begin
          osc_halt_next = 1'b0;
          busy_next = 1'b0;
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_reg <= ST_RUN;
      acc_reg <= `ACC_RESET;
      status_reg <= `STATUS_RESET;
      pc_reg <= `PC_RESET;
      pc_load_reg <= 1'b0;
      stack_pop_reg <= 1'b0;
      flush_reg <= 1'b0;
      file_we_reg <= 1'b0;
      file_waddr_reg <= 7'h00;
      file_wdata_reg <= 8'h00;
      wdt_clear_reg <= 1'b0;
      wdt_value_reg <= 8'h00;
      wdt_prescale_reg <= 8'h00;
      osc_halt_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      status_reg <= status_next;
      pc_reg <= pc_next;
      pc_load_reg <= pc_load_next;
      stack_pop_reg <= stack_pop_next;
      flush_reg <= flush_next;
      file_we_reg <= file_we_next;
      file_waddr_reg <= file_waddr_next;
      file_wdata_reg <= file_wdata_next;
      wdt_clear_reg <= wdt_clear_next;
      wdt_value_reg <= wdt_value_next;
      wdt_prescale_reg <= wdt_prescale_next;
      osc_halt_reg <= osc_halt_next;
      busy_reg <= busy_next;
    end
  end
endmodule : tail_exec
`default_nettype wire

// [test/tail_exec_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "tail_exec_defs.svh"
module tail_exec_monitor
  import tail_exec_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic srst, // Reset
  input wire logic instr_valid, // Offer
  input wire instr_t instr, // Fields
  input wire logic [7:0] file_rdata, // Operand
  input wire logic [12:0] stack_head, // Stack top
  input wire logic [7:0] acc_reg, // Acc
  input wire logic [7:0] status_reg, // Flags
  input wire logic [12:0] pc_reg, // PC
  input wire logic pc_load_reg, // Load
  input wire logic stack_pop_reg, // Pop
  input wire logic flush_reg, // Flush
  input wire logic file_we_reg, // Write
  input wire logic [6:0] file_waddr_reg, // Address
  input wire logic [7:0] file_wdata_reg, // Data
  input wire logic wdt_clear_reg, // Clear
  input wire logic [7:0] wdt_value_reg, // Count
  input wire logic [7:0] wdt_prescale_reg, // Prescale
  input wire logic osc_halt_reg, // Halt
  input wire logic busy_reg // Busy
);
  logic [7:0] a_q, k_q, f_q;
  logic [2:0] go;
  assign go = (instr_valid && !busy_reg) ? instr.op : `OP_NONE;
  // Operands as they stood at the taking edge, so a result can be judged one cycle later.
  always_ff @(posedge sys_clk)
  begin
    a_q <= acc_reg;
    k_q <= instr.literal;
    f_q <= file_rdata;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_ret_load: assert property (go == `OP_RETURN |=> pc_load_reg && stack_pop_reg &&
    flush_reg && pc_reg == $past(stack_head) && status_reg == $past(status_reg))
    else $error("bad return");
  a_ret_dead: assert property (go == `OP_RETURN |=> busy_reg ##1
    (!busy_reg && !pc_load_reg && !stack_pop_reg && !flush_reg))
    else $error("bad return timing");
  a_sleep_wdt: assert property (go == `OP_SLEEP |=> wdt_clear_reg &&
    wdt_value_reg == 8'h00 && wdt_prescale_reg == 8'h00 &&
    status_reg == (($past(status_reg) | 8'h10) & 8'hF7))
    else $error("bad sleep flags");
  a_sleep_halt: assert property (go == `OP_SLEEP |=> osc_halt_reg && busy_reg)
    else $error("no halt");
  a_lit_sub: assert property (go == `OP_LIT_SUB |=> acc_reg == 8'(k_q - a_q) &&
    status_reg[0] == (k_q >= a_q) && status_reg[1] == (k_q[3:0] >= a_q[3:0]) &&
    status_reg[2] == (acc_reg == 8'h00)) else $error("bad literal subtract");
  a_file_dest: assert property (go == `OP_FILE_SUB && instr.dest_file |=>
    file_we_reg && file_waddr_reg == $past(instr.file_addr) &&
    file_wdata_reg == 8'(f_q - a_q) && acc_reg == a_q)
    else $error("bad file subtract");
  a_xor_acc: assert property (go == `OP_FILE_XOR && !instr.dest_file |=>
    !file_we_reg && acc_reg == (a_q ^ f_q) && status_reg[2] == ((a_q ^ f_q) == 8'h00) &&
    status_reg[1:0] == $past(status_reg[1:0])) else $error("bad xor");
  a_lit_xor: assert property (go == `OP_LIT_XOR |=> acc_reg == (a_q ^ k_q) &&
    !file_we_reg && status_reg[2] == ((a_q ^ k_q) == 8'h00) &&
    status_reg[1:0] == $past(status_reg[1:0])) else $error("bad literal xor");
  a_swap_flags: assert property (go == `OP_NIBBLE |=> status_reg == $past(status_reg) &&
    ($past(instr.dest_file) ? file_we_reg && file_wdata_reg == {f_q[3:0], f_q[7:4]} :
    acc_reg == {f_q[3:0], f_q[7:4]})) else $error("bad swap");
endmodule : tail_exec_monitor
bind tail_exec tail_exec_monitor u_mon (
  .sys_clk(sys_clk),
  .srst(srst),
  .instr_valid(instr_valid),
  .instr(instr),
  .file_rdata(file_rdata),
  .stack_head(stack_head),
  .acc_reg(acc_reg),
  .status_reg(status_reg),
  .pc_reg(pc_reg),
  .pc_load_reg(pc_load_reg),
  .stack_pop_reg(stack_pop_reg),
  .flush_reg(flush_reg),
  .file_we_reg(file_we_reg),
  .file_waddr_reg(file_waddr_reg),
  .file_wdata_reg(file_wdata_reg),
  .wdt_clear_reg(wdt_clear_reg),
  .wdt_value_reg(wdt_value_reg),
  .wdt_prescale_reg(wdt_prescale_reg),
  .osc_halt_reg(osc_halt_reg),
  .busy_reg(busy_reg)
);
`default_nettype wire

// [test/cpu_tail_instruction_exec_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "tail_exec_defs.svh"
module cpu_tail_instruction_exec_tb_top import tail_exec_pkg::*;;
  logic sys_clk = 1'b0, srst = 1'b1, instr_valid = 1'b0, wake = 1'b0;
  instr_t instr = '0;
  logic [7:0] file_rdata = 8'h00, acc_reg, status_reg, file_wdata_reg;
  logic [7:0] wdt_value_reg, wdt_prescale_reg;
  logic [12:0] stack_head = 13'h1ABC, pc_reg;
  logic [6:0] file_waddr_reg;
  logic pc_load_reg, stack_pop_reg, flush_reg, file_we_reg, wdt_clear_reg, osc_halt_reg, busy_reg;
  int n_fail = 0, checks = 0;
  tail_exec u_dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .instr_valid(instr_valid),
    .instr(instr),
    .file_rdata(file_rdata),
    .stack_head(stack_head),
    .wake(wake),
    .acc_reg(acc_reg),
    .status_reg(status_reg),
    .pc_reg(pc_reg),
    .pc_load_reg(pc_load_reg),
    .stack_pop_reg(stack_pop_reg),
    .flush_reg(flush_reg),
    .file_we_reg(file_we_reg),
    .file_waddr_reg(file_waddr_reg),
    .file_wdata_reg(file_wdata_reg),
    .wdt_clear_reg(wdt_clear_reg),
    .wdt_value_reg(wdt_value_reg),
    .wdt_prescale_reg(wdt_prescale_reg),
    .osc_halt_reg(osc_halt_reg),
    .busy_reg(busy_reg)
  );
  always #5 sys_clk = ~sys_clk;
  task chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t mismatch %h %h", $time, got, exp);
    end
  endtask : chk
  task run(input logic [2:0] op, input logic [7:0] k, fr, input logic d, input logic [16:0] e);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr <= {op, k, k[6:0], d};
    file_rdata <= fr;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    chk({file_we_reg, acc_reg, status_reg}, e);
  endtask : run
  task t_lit;
    run(`OP_LIT_SUB, 8'h05, 8'h00, 1'b0, 17'h0051B);
    run(`OP_LIT_SUB, 8'h03, 8'h00, 1'b0, 17'h0FE18);
    run(`OP_LIT_SUB, 8'hFE, 8'h00, 1'b0, 17'h0001F);
    run(`OP_LIT_XOR, 8'h5A, 8'h00, 1'b0, 17'h05A1B);
    run(`OP_LIT_XOR, 8'h5A, 8'h00, 1'b0, 17'h0001F);
    // An empty op code must leave every result alone, even with the file destination chosen.
    run(`OP_NONE, 8'hFF, 8'h00, 1'b1, 17'h0001F);
  endtask : t_lit
  task t_file;
    run(`OP_LIT_SUB, 8'h30, 8'h00, 1'b0, 17'h0301B);
    run(`OP_FILE_SUB, 8'h7F, 8'h20, 1'b1, 17'h1301A);
    chk({file_waddr_reg, file_wdata_reg}, 15'h7FF0);
    run(`OP_FILE_SUB, 8'h00, 8'h30, 1'b0, 17'h0001F);
    run(`OP_FILE_XOR, 8'h7F, 8'h0F, 1'b1, 17'h1001B);
    chk({file_waddr_reg, file_wdata_reg}, 15'h7F0F);
    run(`OP_NIBBLE, 8'h7F, 8'hA5, 1'b1, 17'h1001B);
    chk(file_wdata_reg, 8'h5A);
    run(`OP_NIBBLE, 8'h00, 8'hC3, 1'b0, 17'h03C1B);
    run(`OP_FILE_XOR, 8'h01, 8'h3C, 1'b0, 17'h0001F);
  endtask : t_file
  task t_ret;
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr <= {`OP_RETURN, 8'h00, 7'h00, 1'b0};
    @(posedge sys_clk);
    // This word lands in the dead cycle and must be dropped.
    instr <= {`OP_LIT_XOR, 8'hFF, 7'h00, 1'b0};
    #1;
    chk({pc_reg, pc_load_reg, stack_pop_reg, flush_reg, busy_reg}, 17'h1ABCF);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    chk({pc_load_reg, busy_reg, acc_reg, status_reg}, 18'h0001F);
    chk({stack_pop_reg, flush_reg}, 2'b00);
  endtask : t_ret
  task t_sleep;
    run(`OP_SLEEP, 8'h00, 8'h00, 1'b0, 17'h00017);
    chk({wdt_clear_reg, wdt_value_reg, wdt_prescale_reg}, 17'h10000);
    chk({osc_halt_reg, busy_reg}, 2'b11);
    run(`OP_LIT_XOR, 8'hFF, 8'h00, 1'b0, 17'h00017);
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    #1;
    chk({osc_halt_reg, busy_reg}, 2'b00);
    run(`OP_LIT_XOR, 8'h81, 8'h00, 1'b0, 17'h08113);
  endtask : t_sleep
  // A reset in mid-run, taken while asleep, must release the halt and accept work at once.
  task t_reset;
    run(`OP_SLEEP, 8'h00, 8'h00, 1'b0, 17'h08113);
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    #1;
    chk({pc_reg, acc_reg, status_reg, osc_halt_reg, busy_reg}, 31'h00000060);
    run(`OP_LIT_SUB, 8'h01, 8'h00, 1'b0, 17'h0011B);
  endtask : t_reset
  task final_report;
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    t_lit();
    t_file();
    t_ret();
    t_sleep();
    t_reset();
    final_report();
  end
  // About thirty times the seventy or so cycles the scenarios need.
  initial
  begin
    #20000;
    n_fail++;
    final_report();
  end
endmodule : cpu_tail_instruction_exec_tb_top
`default_nettype wire
